// ===== design/mcsd_decoder.sv
// serial command decoder and status flag register of a stepper driver
module mcsd_decoder
   import mcsd_pkg::*;
#(
   parameter logic [31:0] REGISTER_SELECTOR_VALID = 32'h03FF_FFFE,
   parameter logic [31:0] REGISTER_SELECTOR_RO = 32'h0000_0000,
   parameter logic [31:0] REGISTER_SELECTOR_COND = 32'h0000_0000,
   parameter logic [63:0] REGISTER_SELECTOR_LEN = 64'hFFFF_FFFF_FFFF_FFFF
)
(
   input wire logic core_clk_i, // core clock, 250 MHz
   input wire logic rst_i, // async reset, active high
   input wire logic ce_i, // clock enable for core state
   input wire logic sclk_i, // serial clock from host, idles high
   input wire logic cs_n_i, // serial chip select, active low
   input wire logic mosi_i, // serial data from host
   output logic miso_o, // serial data to host
   input wire logic undervoltage_i, // lockout condition, pin
   input wire logic thermal_warn_i, // thermal warning condition, pin
   input wire logic thermal_sd_i, // thermal shutdown condition, pin
   input wire logic overcurrent_i, // overcurrent condition, pin
   input wire logic stall_a_i, // stall on bridge a, pin
   input wire logic stall_b_i, // stall on bridge b, pin
   input wire logic limit_contact_input_i, // switch pin, low when closed
   input wire logic step_pulse_input_i, // step clock pin
   input wire logic busy_i, // engine executing a command
   input wire logic [1:0] motion_state_i, // engine motion state
   input wire logic travel_sense_i, // engine direction, 1 forward
   output logic cmd_valid_o, // one-cycle command strobe
   output mcsd_pkg::mcsd_cmd_t cmd_code_o, // command kind
   output logic cmd_dir_o, // direction bit of the command
   output logic cmd_act_o, // trigger_op bit of the command
   output logic [23:0] cmd_arg_o, // argument bytes, msb first
   output logic step_tick_o, // step pulse in step-clock mode
   output logic busy_n_o, // busy pin, low while executing
   output logic bridges_off_o // bridges held in high impedance
);
   // serial domain
   logic [2:0] bit_cnt;
   logic [6:0] rx_sh;
   logic [7:0] rx_byte, tx_hold;
   logic rx_tgl;
   wire spi_rst = rst_i | cs_n_i;
   // bit counter and shifter end with the frame's own select
   always_ff @(posedge sclk_i or posedge spi_rst)
   begin
      if (spi_rst)
      begin
         bit_cnt <= 3'h0;
         rx_sh <= 7'h00;
      end
      else
      begin
         bit_cnt <= bit_cnt + 3'h1;
         rx_sh <= {rx_sh[5:0], mosi_i};
      end
   end
   // finished byte is held and announced by a toggle
   always_ff @(posedge sclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rx_byte <= 8'h00;
         rx_tgl <= 1'b0;
      end
      else if (!cs_n_i && bit_cnt == 3'h7)
      begin
         rx_byte <= {rx_sh, mosi_i};
         rx_tgl <= ~rx_tgl;
      end
   end
   // tx_hold is quiet during a frame, the host gap guarantees it
   assign miso_o = cs_n_i ? 1'b0 : tx_hold[~bit_cnt];

   // core domain: synchronisers
   logic [SYNC_W-1:0] sy1, sy2;
   logic [1:0] sy_prev;
   logic tg1, tg2, tg3;
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sy1 <= 8'hC0;
         sy2 <= 8'hC0;
         sy_prev <= 2'h3;
         tg1 <= 1'b0;
         tg2 <= 1'b0;
         tg3 <= 1'b0;
      end
      else if (ce_i)
      begin
         sy1 <= {step_pulse_input_i, limit_contact_input_i, stall_b_i, stall_a_i,
                 overcurrent_i, thermal_sd_i, thermal_warn_i, undervoltage_i};
         sy2 <= sy1;
         sy_prev <= sy2[SI_STEP:SI_CONTACT];
         tg1 <= rx_tgl;
         tg2 <= tg1;
         tg3 <= tg2;
      end
   end

   // opcode table
   function automatic mcsd_cmd_t decode_op(input logic [7:0] op);
      logic [1:0] s;
      logic z;
      s = op[4:3];
      z = (op[2:1] == SUB_00);
      decode_op = cmd_unk;
      case (op[7:5])
         GRP_PARW: decode_op = (op[4:0] == 5'h00) ? cmd_nop : cmd_wrp;
         GRP_PARR: decode_op = cmd_rdp;
         GRP_DRV:
            if (z)
               decode_op = (s == SUB_10) ? cmd_run : (s == SUB_11) ? cmd_pulse :
                           (s == SUB_00) ? cmd_move : cmd_unk;
         GRP_SEEK:
            if (z)
               decode_op = (s == SUB_01) ? cmd_seekd : op[0] ? cmd_unk :
                           (s == SUB_00) ? cmd_seek :
                           (s == SUB_10) ? cmd_orig : cmd_mark;
         GRP_SW:
            if (op[2:1] == SW_LOW_BITS)
               decode_op = op[4] ? cmd_backoff : cmd_seeksw;
         GRP_STOP:
            if (z && !op[0])
               decode_op = (s == SUB_10) ? cmd_rhalt : (s == SUB_11) ? cmd_ihalt :
                           (s == SUB_00) ? cmd_rfloat : cmd_ifloat;
         GRP_SYS:
            if (z && !op[0])
               decode_op = (s == SUB_11) ? cmd_clrpos : (s == SUB_00) ? cmd_freset :
                           (s == SUB_10) ? cmd_rdflags : cmd_unk;
         default: decode_op = cmd_unk;
      endcase
   endfunction
   // byte length of a parameter register
   function automatic logic [1:0] plen(input logic [4:0] sel);
      plen = (sel == STATUS_SEL) ? STATUS_LEN : REGISTER_SELECTOR_LEN[{sel, 1'b0} +: 2];
   endfunction
   // commands followed by a three-byte argument
   function automatic logic has_args(input mcsd_cmd_t c);
      has_args = c inside {cmd_run, cmd_move, cmd_seek, cmd_seekd, cmd_seeksw};
   endfunction
   // commands that start a motion, leaving step-clock mode
   function automatic logic is_motion(input mcsd_cmd_t c);
      is_motion = c inside {cmd_run, cmd_move, cmd_seek, cmd_seekd, cmd_orig,
                            cmd_mark, cmd_seeksw, cmd_backoff};
   endfunction
   // core state
   logic [1:0] arg_left, resp_left;
   mcsd_cmd_t cur_cmd;
   logic [7:0] cur_op;
   logic [15:0] arg_buf;
   logic [23:0] resp;
   logic [LF_W-1:0] latched;
   logic bridges_off_flag, float_pend, pulse_drive_cmd_mode_flag;
   logic [23:0] register_selector_mem [32];
   logic [15:0] status_w;
   // byte arrival and decode
   wire evt = tg2 ^ tg3;
   wire [4:0] sel = rx_byte[4:0];
   wire [4:0] cur_sel = cur_op[4:0];
   mcsd_cmd_t dec_w;
   assign dec_w = decode_op(rx_byte);
   wire new_op = evt & (arg_left == 2'h0);
   wire last_arg = evt & (arg_left == 2'h1);
   wire running = (motion_state_i != MOT_STOPPED) & ~pulse_drive_cmd_mode_flag;
   wire sel_ok = (sel == STATUS_SEL) | REGISTER_SELECTOR_VALID[sel];
   wire sel_wr_ok = (sel == STATUS_SEL) | (REGISTER_SELECTOR_VALID[sel] & ~REGISTER_SELECTOR_RO[sel]);
   // error classification
   wire unk_op = new_op & ((dec_w == cmd_unk) |
                 (dec_w == cmd_wrp & ~sel_wr_ok) |
                 (dec_w == cmd_rdp & ~sel_ok));
   wire ref_op = new_op & (dec_w == cmd_pulse) & running;
   wire wr_fail = (cur_cmd == cmd_wrp) &
                  ((cur_sel == STATUS_SEL) |
                   (REGISTER_SELECTOR_COND[cur_sel] & running));
   wire mv_fail = (cur_cmd == cmd_move) & running;
   wire ref_arg = last_arg & (wr_fail | mv_fail);
   wire acc_op = new_op & ~unk_op & ~ref_op;
   // argument count and execution strobes
   wire [1:0] nargs = (dec_w == cmd_wrp) ? plen(sel) :
                      has_args(dec_w) ? MOTION_ARG_LEN : 2'h0;
   wire exec_op = acc_op & (nargs == 2'h0) & (dec_w != cmd_nop) &
                  (dec_w != cmd_rdp) & (dec_w != cmd_rdflags);
   wire exec_arg = last_arg & ~ref_arg & (cur_cmd != cmd_wrp);
   wire par_wr = last_arg & ~ref_arg & (cur_cmd == cmd_wrp);
   wire exec_any = exec_op | exec_arg;
   mcsd_cmd_t exec_cmd;
   assign exec_cmd = exec_op ? dec_w : cur_cmd;
   wire [7:0] exec_byte = exec_op ? rx_byte : cur_op;
   wire [23:0] arg_full = {arg_buf, rx_byte};
   wire init = exec_any & (exec_cmd == cmd_freset);
   wire clr_flags = acc_op & (dec_w == cmd_rdflags);
   // response selection, snapshot taken at decode
   wire rd_status = (dec_w == cmd_rdflags) | (sel == STATUS_SEL);
   wire resp_load = acc_op & ((dec_w == cmd_rdflags) | (dec_w == cmd_rdp));
   wire [1:0] resp_len = rd_status ? STATUS_LEN : plen(sel);
   wire [23:0] rd_val = rd_status ? {8'h00, status_w} : register_selector_mem[sel];
   wire [23:0] rd_just = (resp_len == 2'h1) ? {rd_val[7:0], 16'h0000} :
                         (resp_len == 2'h2) ? {rd_val[15:0], 8'h00} : rd_val;
   // command sequencing and answer bytes
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         arg_left <= 2'h0;
         cur_cmd <= cmd_nop;
         cur_op <= 8'h00;
         arg_buf <= 16'h0000;
         resp <= 24'h000000;
         resp_left <= 2'h0;
         tx_hold <= 8'h00;
      end
      else if (ce_i && evt)
      begin
         if (new_op)
         begin
            arg_left <= unk_op ? 2'h0 : nargs;
            cur_cmd <= dec_w;
            cur_op <= rx_byte;
            arg_buf <= 16'h0000;
         end
         else
         begin
            arg_left <= arg_left - 2'h1;
            arg_buf <= arg_full[15:0];
         end
         // a new read aborts whatever answer is still pending
         if (resp_load)
         begin
            tx_hold <= rd_just[23:16];
            resp <= {rd_just[15:0], 8'h00};
            resp_left <= resp_len - 2'h1;
         end
         else if (resp_left != 2'h0)
         begin
            tx_hold <= resp[23:16];
            resp <= {resp[15:0], 8'h00};
            resp_left <= resp_left - 2'h1;
         end
         else
            tx_hold <= 8'h00;
      end
   end
   // parameter store
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 32; i++)
            register_selector_mem[i] <= 24'h000000;
      end
      else if (ce_i)
      begin
         if (init)
         begin
            for (int i = 0; i < 32; i++)
               register_selector_mem[i] <= 24'h000000;
         end
         else if (par_wr)
            register_selector_mem[cur_sel] <= arg_full;
      end
   end
   // latched events: a set in the clearing cycle wins
   wire contact_fall = sy_prev[0] & ~sy2[SI_CONTACT];
   wire [LF_W-1:0] set_v = {contact_fall, unk_op, ref_op | ref_arg,
                            sy2[LF_STALLB:LF_UV]};
   wire [LF_W-1:0] next_latched = set_v | (latched & ~{LF_W{clr_flags}});
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         latched <= LF_RESET;
      else if (ce_i)
         latched <= init ? LF_RESET : next_latched;
   end

   // bridges, step-clock mode and busy pin
   wire force_hiz = latched[LF_THSD] | latched[LF_OCD];
   wire leave_hiz = exec_any & (is_motion(exec_cmd) | exec_cmd == cmd_rhalt |
                                exec_cmd == cmd_ihalt);
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bridges_off_flag <= 1'b1;
         float_pend <= 1'b0;
         pulse_drive_cmd_mode_flag <= 1'b0;
         busy_n_o <= 1'b1;
      end
      else if (ce_i)
      begin
         busy_n_o <= ~busy_i;
         if (init || force_hiz || (exec_any && exec_cmd == cmd_ifloat))
            bridges_off_flag <= 1'b1;
         else if (leave_hiz)
            bridges_off_flag <= 1'b0;
         else if (float_pend && motion_state_i == MOT_STOPPED)
            bridges_off_flag <= 1'b1;
         // ramped float waits for the engine to reach standstill
         if (init || leave_hiz || motion_state_i == MOT_STOPPED)
            float_pend <= exec_any && exec_cmd == cmd_rfloat && !init;
         else if (exec_any && exec_cmd == cmd_rfloat)
            float_pend <= 1'b1;
         if (init || (exec_any && is_motion(exec_cmd)))
            pulse_drive_cmd_mode_flag <= 1'b0;
         else if (exec_any && exec_cmd == cmd_pulse)
            pulse_drive_cmd_mode_flag <= 1'b1;
      end
   end
   // command strobe to the motion engine and step pulses
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cmd_valid_o <= 1'b0;
         cmd_code_o <= cmd_nop;
         cmd_dir_o <= 1'b0;
         cmd_act_o <= 1'b0;
         cmd_arg_o <= 24'h000000;
         step_tick_o <= 1'b0;
      end
      else if (ce_i)
      begin
         cmd_valid_o <= exec_any;
         step_tick_o <= pulse_drive_cmd_mode_flag & sy2[SI_STEP] & ~sy_prev[1];
         if (exec_any)
         begin
            cmd_code_o <= exec_cmd;
            cmd_dir_o <= exec_byte[0];
            cmd_act_o <= exec_byte[3];
            cmd_arg_o <= exec_arg ? arg_full : 24'h000000;
         end
      end
   end
   // status word msb first, active-low faults inverted from the latches
   assign status_w = {pulse_drive_cmd_mode_flag, ~latched[LF_STALLB:LF_UV],
                      latched[LF_UNKNOWN], latched[LF_REFUSED],
                      motion_state_i, travel_sense_i, latched[LF_EVENT],
                      ~sy2[SI_CONTACT], busy_n_o, bridges_off_flag};
   assign bridges_off_o = bridges_off_flag;

   // checks on the core domain
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   unknown_opcode_a: assert property (ce_i && new_op && dec_w == cmd_unk |=>
      status_w[ST_UNKNOWN] && arg_left == 2'h0)
      else $error("undefined opcode not flagged");
   status_write_a: assert property (ce_i && last_arg && cur_cmd == cmd_wrp &&
      cur_sel == STATUS_SEL |=> status_w[ST_REFUSED] && !cmd_valid_o)
      else $error("status write not refused");
   uv_latch_a: assert property (ce_i && !status_w[ST_UV] && !clr_flags |=>
      !status_w[ST_UV])
      else $error("undervoltage flag released without read");
   busy_pin_a: assert property (ce_i && busy_i |=> !status_w[ST_BUSY])
      else $error("busy bit not low while engine busy");
   contact_event_a: assert property (ce_i && contact_fall |=> status_w[ST_EVENT])
      else $error("contact closure not latched");
   bridges_force_a: assert property (ce_i && force_hiz |=> bridges_off_flag)
      else $error("bridges left active under fault");
   stepclk_mode_a: assert property (ce_i && exec_any && exec_cmd == cmd_pulse |=>
      status_w[ST_STEPCLK] && cmd_valid_o)
      else $error("step-clock mode not entered");
   zero_answer_a: assert property (ce_i && evt && !resp_load && resp_left == 2'h0 |=>
      tx_hold == 8'h00)
      else $error("nonzero answer without read");
   flags_answer_a: assert property (ce_i && clr_flags |=>
      tx_hold == $past(status_w[15:8]) && resp[23:16] == $past(status_w[7:0]))
      else $error("status answer not snapshot msb first");
endmodule // mcsd_decoder

// ===== pkg/mcsd_pkg.sv
// shared types and constants of the motor command and status decoder
package mcsd_pkg;
   // decoded command kinds
   typedef enum logic [4:0] {
      cmd_nop, cmd_wrp, cmd_rdp, cmd_run, cmd_pulse, cmd_move, cmd_seek, cmd_seekd,
      cmd_orig, cmd_mark, cmd_seeksw, cmd_backoff, cmd_rhalt, cmd_ihalt,
      cmd_rfloat, cmd_ifloat, cmd_clrpos, cmd_freset, cmd_rdflags, cmd_unk
   } mcsd_cmd_t;

   // opcode groups in bits [7:5]
   localparam logic [2:0] GRP_PARW = 3'h0;
   localparam logic [2:0] GRP_PARR = 3'h1;
   localparam logic [2:0] GRP_DRV = 3'h2;
   localparam logic [2:0] GRP_SEEK = 3'h3;
   localparam logic [2:0] GRP_SW = 3'h4;
   localparam logic [2:0] GRP_STOP = 3'h5;
   localparam logic [2:0] GRP_SYS = 3'h6;
   // sub codes in bits [4:3], and the fixed pattern of bits [2:1]
   localparam logic [1:0] SUB_00 = 2'h0;
   localparam logic [1:0] SUB_01 = 2'h1;
   localparam logic [1:0] SUB_10 = 2'h2;
   localparam logic [1:0] SUB_11 = 2'h3;
   localparam logic [1:0] SW_LOW_BITS = 2'h1;

   // selector of the status register, byte counts and the stopped motion state
   localparam logic [4:0] STATUS_SEL = 5'h19;
   localparam logic [1:0] STATUS_LEN = 2'h2;
   localparam logic [1:0] MOTION_ARG_LEN = 2'h3;
   localparam logic [1:0] MOT_STOPPED = 2'h0;

   // status word bit positions
   localparam int ST_BRIDGES = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_LEVEL = 2;
   localparam int ST_EVENT = 3;
   localparam int ST_DIR = 4;
   localparam int ST_MOT = 5;
   localparam int ST_REFUSED = 7;
   localparam int ST_UNKNOWN = 8;
   localparam int ST_UV = 9;
   localparam int ST_THWRN = 10;
   localparam int ST_THSD = 11;
   localparam int ST_OCD = 12;
   localparam int ST_STALLA = 13;
   localparam int ST_STALLB = 14;
   localparam int ST_STEPCLK = 15;

   // latched event vector (active high inside), same order as synchroniser
   localparam int LF_UV = 0;
   localparam int LF_THWRN = 1;
   localparam int LF_THSD = 2;
   localparam int LF_OCD = 3;
   localparam int LF_STALLA = 4;
   localparam int LF_STALLB = 5;
   localparam int LF_REFUSED = 6;
   localparam int LF_UNKNOWN = 7;
   localparam int LF_EVENT = 8;
   localparam int LF_W = 9;
   localparam logic [8:0] LF_RESET = 9'h001;

   // pins passing the two-flop synchroniser
   localparam int SI_CONTACT = 6;
   localparam int SI_STEP = 7;
   localparam int SYNC_W = 8;
endpackage

// ===== test/mcsd_decoder_tb_top.sv
// self-checking bench of the motor command and status decoder
module mcsd_decoder_tb_top;
   import mcsd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic sclk, cs_n, mosi, miso, step_pin, cmd_valid_o, cmd_dir_o, cmd_act_o, step_tick_o;
   logic busy_n_o, bridges_off_o, busy_i = 1'b0, limit_i = 1'b1, dir_i = 1'b1;
   logic [1:0] mot_i = 2'h0;
   logic [5:0] fault_i = 6'h00; // uv, twarn, tsd, ocd, stall a, stall b
   logic [23:0] cmd_arg_o, last_arg;
   mcsd_cmd_t cmd_code_o, last_code;
   logic last_dir, last_act;
   logic [7:0] rx;
   logic [15:0] st;
   int n_cmd = 0, n_tick = 0, mismatches = 0, cmp_count = 0;

   always #2 core_clk_i = ~core_clk_i;

   mcsd_host mcsd_host_i (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .step_o(step_pin),
      .miso_i(miso));
   mcsd_decoder #(.REGISTER_SELECTOR_COND(32'h0000_0040)) mcsd_decoder_i (.core_clk_i(core_clk_i),
      .rst_i(rst_i), .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
      .undervoltage_i(fault_i[5]), .thermal_warn_i(fault_i[4]), .thermal_sd_i(fault_i[3]),
      .overcurrent_i(fault_i[2]), .stall_a_i(fault_i[1]), .stall_b_i(fault_i[0]),
      .limit_contact_input_i(limit_i), .step_pulse_input_i(step_pin), .busy_i(busy_i),
      .motion_state_i(mot_i), .travel_sense_i(dir_i), .cmd_valid_o(cmd_valid_o),
      .cmd_code_o(cmd_code_o), .cmd_dir_o(cmd_dir_o), .cmd_act_o(cmd_act_o),
      .cmd_arg_o(cmd_arg_o), .step_tick_o(step_tick_o), .busy_n_o(busy_n_o),
      .bridges_off_o(bridges_off_o));

   // one-cycle strobes are caught here so tasks can judge them later
   always @(posedge core_clk_i)
   begin
      if (cmd_valid_o === 1'b1)
      begin
         n_cmd <= n_cmd + 1;
         last_code <= cmd_code_o;
         last_dir <= cmd_dir_o;
         last_act <= cmd_act_o;
         last_arg <= cmd_arg_o;
      end
      if (step_tick_o === 1'b1)
         n_tick <= n_tick + 1;
   end

   task automatic report_and_stop();
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         $display("mismatch %s expected %h seen %h", what, exp, seen);
         mismatches++;
      end
   endtask

   // opcode then n argument bytes, first byte highest
   task automatic send(input logic [7:0] op, input int n, input logic [23:0] arg);
      mcsd_host_i.xfer(op, rx);
      for (int i = n - 1; i >= 0; i--)
         mcsd_host_i.xfer(arg[8*i +: 8], rx);
   endtask

   // command that must strobe the engine, bounded wait for the strobe
   task automatic run_cmd(input logic [7:0] op, input int n, input logic [23:0] arg);
      int start;
      start = n_cmd;
      send(op, n, arg);
      for (int k = 0; k < 50 && n_cmd == start; k++)
         @(posedge core_clk_i);
      if (n_cmd == start)
      begin
         mismatches++;
         report_and_stop();
      end
   endtask

   task automatic get_status();
      mcsd_host_i.xfer(8'hD0, rx);
      mcsd_host_i.xfer(8'h00, rx);
      st[15:8] = rx;
      mcsd_host_i.xfer(8'h00, rx);
      st[7:0] = rx;
   endtask

   task automatic sc_reset_flags();
      get_status();
      check("status after reset", st, 16'h7C13);
      get_status();
      check("uv cleared by read", st[15:8], 8'h7E);
      send(8'hE0, 0, 24'h0);
      get_status();
      check("unknown opcode", st[15:8], 8'h7F);
      get_status();
      check("unknown cleared", st[15:8], 8'h7E);
   endtask

   task automatic sc_faults();
      @(posedge core_clk_i) fault_i <= 6'h3F;
      repeat (10) @(posedge core_clk_i);
      fault_i <= 6'h00;
      repeat (10) @(posedge core_clk_i);
      get_status();
      check("faults latched low", st[15:8], 8'h00);
      get_status();
      check("faults cleared", st[15:8], 8'h7E);
   endtask

   task automatic sc_pulse_drive_cmd();
      run_cmd(8'h59, 0, 24'h0);
      check("pulse drive code", last_code, cmd_pulse);
      mcsd_host_i.step_pulse();
      mcsd_host_i.step_pulse();
      check("step ticks", n_tick, 2);
      get_status();
      check("step mode flag", st[15:8], 8'hFE);
   endtask

   task automatic sc_decode();
      logic [7:0] ops [14] = '{8'h51, 8'h40, 8'h60, 8'h69, 8'h8B, 8'h92, 8'h9B,
         8'h70, 8'h78, 8'hD8, 8'hB8, 8'hA8, 8'hA0, 8'hB0};
      mcsd_cmd_t codes [14] = '{cmd_run, cmd_move, cmd_seek, cmd_seekd, cmd_seeksw,
         cmd_backoff, cmd_backoff, cmd_orig, cmd_mark, cmd_clrpos, cmd_ihalt, cmd_ifloat,
         cmd_rfloat, cmd_rhalt};
      for (int i = 0; i < 14; i++)
      begin
         run_cmd(ops[i], (i < 5) ? 3 : 0, 24'hABCDEF);
         check("code", last_code, codes[i]);
         check("dir", last_dir, ops[i][0]);
         check("act", last_act, ops[i][3]);
         check("arg", last_arg, (i < 5) ? 24'hABCDEF : 24'h0);
         if (i == 0)
            check("bridges on after run", bridges_off_o, 1'b0);
         if (i == 11)
            check("bridges off after float", bridges_off_o, 1'b1);
      end
   endtask

   task automatic sc_register_selector();
      logic [7:0] exp [4] = '{8'h12, 8'h34, 8'h56, 8'h00};
      send(8'h05, 3, 24'h123456);
      mcsd_host_i.xfer(8'h25, rx);
      check("read answer opcode", rx, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         mcsd_host_i.xfer(8'h00, rx);
         check("read register_selector byte", rx, exp[i]);
      end
      mcsd_host_i.xfer(8'h25, rx);
      mcsd_host_i.xfer(8'hD0, rx);
      check("first byte before abort", rx, 8'h12);
      mcsd_host_i.xfer(8'h00, rx);
      check("new answer after abort", rx, 8'h7E);
      mcsd_host_i.xfer(8'h00, rx);
      send(8'h19, 2, 24'h00FFFF);
      get_status();
      check("status write refused", st[7], 1'b1);
      check("status not written", st[15:8], 8'h7E);
   endtask

   task automatic sc_pins();
      @(posedge core_clk_i) busy_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      check("busy pin", busy_n_o, 1'b0);
      limit_i <= 1'b0;
      repeat (10) @(posedge core_clk_i);
      get_status();
      check("busy bit and contact", st[3:1], 3'h6);
      @(posedge core_clk_i) limit_i <= 1'b1;
      busy_i <= 1'b0;
      repeat (10) @(posedge core_clk_i);
      get_status();
      check("contact open, event cleared", st[3:1], 3'h1);
   endtask

   // engine running: refusals; selector 6 is made conditional at the instance
   task automatic sc_running();
      int n;
      @(posedge core_clk_i) mot_i <= 2'h3;
      dir_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      get_status();
      check("motion state and dir", st[7:0], 8'h62);
      n = n_cmd;
      send(8'h59, 0, 24'h0);
      get_status();
      check("pulse drive refused", {st[15], st[8:7]}, 3'h1);
      send(8'h40, 3, 24'hABCDEF);
      get_status();
      check("move refused", st[7], 1'b1);
      send(8'h06, 3, 24'h111111);
      get_status();
      check("conditional write refused", st[7], 1'b1);
      check("no strobe while refused", n_cmd - n, 0);
      @(posedge core_clk_i) mot_i <= 2'h0;
      dir_i <= 1'b1;
      send(8'h1F, 0, 24'h0);
      get_status();
      check("bad write target", st[8:7], 2'h2);
   endtask

   // full reset command restores the power-up state and clears parameters
   task automatic sc_full_reset();
      run_cmd(8'hC0, 0, 24'h0);
      check("full reset code", last_code, cmd_freset);
      check("bridges off after reset", bridges_off_o, 1'b1);
      get_status();
      check("status after full reset", st, 16'h7C13);
      mcsd_host_i.xfer(8'h25, rx);
      mcsd_host_i.xfer(8'h00, rx);
      check("parameters zeroed", rx, 8'h00);
   endtask

   initial
   begin
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      sc_reset_flags();
      sc_faults();
      sc_pulse_drive_cmd();
      sc_decode();
      sc_register_selector();
      sc_pins();
      sc_running();
      sc_full_reset();
      report_and_stop();
   end
endmodule // mcsd_decoder_tb_top

// ===== test/mcsd_host.sv
// host microcontroller model: serial bus master and step pin driver
module mcsd_host
(
   output logic sclk_o, // serial clock, idles high
   output logic cs_n_o, // chip select, active low
   output logic mosi_o, // data to the device
   output logic step_o, // step clock pin
   input wire logic miso_i // data from the device
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus at time zero
   initial
   begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
      step_o = 1'b0;
   end

   // one full-duplex byte, msb first; the clock only runs inside the frame
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      cs_n_o = 1'b0;
      #3;
      for (int i = 7; i >= 0; i--)
      begin
         sclk_o = 1'b0;
         mosi_o = tx[i];
         #3;
         rx = {rx[6:0], miso_i};
         sclk_o = 1'b1;
         #3;
      end
      cs_n_o = 1'b1;
      mosi_o = ~mosi_o; // released line must not hold the last bit
      #40; // gap lets the answer settle before the next frame
   endtask

   // one step pulse, slow enough for the pin synchroniser
   task automatic step_pulse();
      step_o = 1'b1;
      #20;
      step_o = 1'b0;
      #20;
   endtask
endmodule // mcsd_host
